//--- src/cacm_module.sv
// Purpose: one capture/compare module of the counter array
// Assumes: shared counter and its tick come from the array on sys_clk
// Notes:   event flag cleared only by a software write to array_control
//          the pin passes a two-stage synchroniser, so a capture lands three clocks after the pin moves
//          a pin held high through reset shows one rising edge once reset is released
`timescale 1ns/1ps
module cacm_module
  import cacm_pkg::*;
#(
  parameter logic [7:0] MODE_ADDR = CACM_MODE0_ADDR  // which mode register this module answers
)
(
  input  wire logic        sys_clk,
  input  wire logic        srst,
  input  wire cacm_sfr_wr_t sfr_wr,
  input  wire logic        flag_clear,
  input  wire logic        low_wr,
  input  wire logic        high_wr,
  input  wire logic [15:0] counter_value,
  input  wire logic        module_io_pin_in,
  output logic             module_io_pin_out,
  output logic             module_io_pin_oe_n,
  output logic             module_io_pin_level,
  output logic [7:0]       module_mode,
  output logic [7:0]       capture_low_byte,
  output logic [7:0]       capture_high_byte,
  output logic             module_event_flag,
  output logic             event_irq
);
  cacm_mode_t  mode_r;      // mode register
  cacm_mode_t  mode_nxt;
  logic [15:0] cap_r;       // capture/compare register
  logic [15:0] cap_nxt;
  logic        flag_r;      // module event flag
  logic        flag_nxt;
  logic        pin_prev_r;  // previous synchronised level, edge detection
  logic        pin_prev_nxt;
  logic        out_r;       // driven pin level
  logic        out_nxt;
  logic        pin_sync;    // synchronised pin
  logic        rise;        // low-to-high seen this cycle
  logic        fall;        // high-to-low seen this cycle
  logic        capture;     // selected edge, loads the capture register
  logic        match;       // counter equals compare value, comparator enabled
  logic        pwm_high;    // pwm output level before registering

  // two flops guard the edge detector against metastability
  cacm_sync u_sync (
    .sys_clk  (sys_clk),
    .srst     (srst),
    .async_in (module_io_pin_in),
    .sync_out (pin_sync)
  );

  // edge detection; two-cycle minimum pulses are seen by the two-stage sampler
  always_comb
  begin
    rise    = pin_sync & ~pin_prev_r;
    fall    = ~pin_sync & pin_prev_r;  // high-to-low seen this cycle
    capture = (rise & mode_r.rising_capture_enable) | (fall & mode_r.falling_capture_enable);
  end

  // comparator; 8-bit pwm compares the low byte only, every other mode the full word
  always_comb
  begin
    if (mode_r.pwm_function_enable & ~mode_r.wide_pwm_select & ~mode_r.toggle_function_enable)
    begin
      match = mode_r.comparator_function_enable & (counter_value[7:0] == cap_r[7:0]);
    end
    else
    begin
      match = mode_r.comparator_function_enable & (counter_value == cap_r);  // full 16-bit compare
    end
  end

  // pwm level: high once the counter reaches the compare value
  // the wide select is read even with pwm off; harmless, since the level is not used then
  always_comb
  begin
    if (mode_r.wide_pwm_select)
    begin
      pwm_high = counter_value >= cap_r;
    end
    else
    begin
      pwm_high = counter_value[7:0] >= cap_r[7:0];  // 8-bit pwm ignores the high bytes
    end
  end

  // mode register: only a write to this module's own address lands
  always_comb
  begin
    mode_nxt = mode_r;  // hold unless addressed
    if (sfr_wr.wr && sfr_wr.addr == MODE_ADDR)
    begin
      mode_nxt = cacm_mode_t'(sfr_wr.data);  // writes to the other modules are refused here
    end
  end

  // mode register storage
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      mode_r <= cacm_mode_t'(CACM_MODE_RESET);  // all functions off, pin released
    end
    else
    begin
      mode_r <= mode_nxt;
    end
  end

  // capture/compare register: byte loads from software, whole-word capture from hardware
  always_comb
  begin
    cap_nxt = cap_r;  // hold by default
    // software loads of the compare value, one byte at a time
    if (low_wr)
    begin
      cap_nxt[7:0] = sfr_wr.data;  // low byte
    end
    if (high_wr)
    begin
      cap_nxt[15:8] = sfr_wr.data;  // high byte
    end
    // hardware capture wins over a same-cycle software load, so a measured edge is never lost
    if (capture)
    begin
      cap_nxt = counter_value;
    end
  end

  // capture register storage
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      cap_r <= CACM_CAP_RESET;
    end
    else
    begin
      cap_r <= cap_nxt;
    end
  end

  // module event flag: set by a capture or a match, cleared only by software
  always_comb
  begin
    flag_nxt = flag_r;  // sticky; taking the interrupt does not clear it
    // clear first, so a same-cycle set wins and no event is dropped
    if (flag_clear)
    begin
      flag_nxt = 1'b0;
    end
    if (capture)
    begin
      flag_nxt = 1'b1;
    end
    if (match && mode_r.match_function_enable)
    begin
      flag_nxt = 1'b1;
    end
  end

  // event flag storage
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      flag_r <= 1'b0;
    end
    else
    begin
      flag_r <= flag_nxt;
    end
  end

  // pin drive and edge history
  always_comb
  begin
    pin_prev_nxt = pin_sync;  // last synchronised level for the edge detector
    out_nxt      = out_r;     // hold the driven level by default
    // toggle, alone or with pwm (frequency output), flips the pin on every match
    if (mode_r.toggle_function_enable && match)
    begin
      out_nxt = ~out_r;
    end
    // pwm alone follows the compare result each cycle
    else if (mode_r.pwm_function_enable && !mode_r.toggle_function_enable)
    begin
      out_nxt = pwm_high;
    end
  end

  // pin drive and edge history storage; history resets to the idle low level
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      pin_prev_r <= 1'b0;
      out_r      <= 1'b0;
    end
    else
    begin
      pin_prev_r <= pin_prev_nxt;
      out_r      <= out_nxt;
    end
  end

  // outputs; pin is driven only in toggle or pwm modes
  // the level readback stays live in every mode, so software can tell which edge captured
  // the interrupt is a plain gate of registered values and adds no delay of its own
  assign module_io_pin_out   = out_r;
  assign module_io_pin_oe_n  = ~(mode_r.toggle_function_enable | mode_r.pwm_function_enable);
  assign module_io_pin_level = pin_sync;
  assign module_mode         = mode_r;
  assign capture_low_byte    = cap_r[7:0];
  assign capture_high_byte   = cap_r[15:8];
  assign module_event_flag   = flag_r;
  assign event_irq           = flag_r & mode_r.event_irq_enable;
endmodule // cacm_module

//--- src/cacm_pkg.sv
// Purpose: shared constants and carriers for the counter array capture/compare module
// Assumes: one module of the array; the shared counter comes from outside
// Notes:   mode register bit positions and addresses kept in one place
package cacm_pkg;
  localparam logic [7:0] CACM_MODE0_ADDR  = 8'hda;   // module 0 mode register address
  localparam logic [7:0] CACM_MODE1_ADDR  = 8'hdb;   // module 1 mode register address
  localparam logic [7:0] CACM_MODE2_ADDR  = 8'hdc;   // module 2 mode register address
  localparam logic [7:0] CACM_MODE_RESET  = 8'h00;   // mode register reset value
  localparam logic [15:0] CACM_CAP_RESET  = 16'h0000; // capture register reset value
  localparam int CACM_WIDE_BIT  = 7;  // wide pwm select
  localparam int CACM_COMP_BIT  = 6;  // comparator function enable
  localparam int CACM_RISE_BIT  = 5;  // rising capture enable
  localparam int CACM_FALL_BIT  = 4;  // falling capture enable
  localparam int CACM_MATCH_BIT = 3;  // match function enable
  localparam int CACM_TOG_BIT   = 2;  // toggle function enable
  localparam int CACM_PWM_BIT   = 1;  // pwm function enable
  localparam int CACM_IRQ_BIT   = 0;  // event irq enable
  localparam int CACM_SYNC_STAGES = 2; // pin synchroniser depth

  // software write strobe with its data
  typedef struct packed {
    logic       wr;
    logic [7:0] addr;
    logic [7:0] data;
  } cacm_sfr_wr_t;

  // decoded mode fields
  typedef struct packed {
    logic wide_pwm_select;
    logic comparator_function_enable;
    logic rising_capture_enable;
    logic falling_capture_enable;
    logic match_function_enable;
    logic toggle_function_enable;
    logic pwm_function_enable;
    logic event_irq_enable;
  } cacm_mode_t;
endpackage

//--- src/cacm_sync.sv
// Purpose: two flip-flop synchroniser for the module pin
// Assumes: input is asynchronous to sys_clk
// Notes:   first stage is read only by the second
`timescale 1ns/1ps
module cacm_sync
  import cacm_pkg::*;
(
  input  wire logic sys_clk,
  input  wire logic srst,
  input  wire logic async_in,
  output logic      sync_out
);
  logic meta_r;   // first stage, metastable
  logic meta_nxt;
  logic sync_r;   // second stage
  logic sync_nxt;

  // next values: plain shift
  always_comb
  begin
    meta_nxt = async_in;
    sync_nxt = meta_r;
  end

  // register stages
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      meta_r <= 1'b0;
      sync_r <= 1'b0;
    end
    else
    begin
      meta_r <= meta_nxt;
      sync_r <= sync_nxt;
    end
  end

  assign sync_out = sync_r;
endmodule // cacm_sync

//--- tb/cacm_module_asserts.sv
// Purpose: checker for one capture/compare module
// Assumes: bench holds the counter still across pin edges
// Notes:   bound to every cacm_module
`timescale 1ns/1ps
module cacm_module_asserts
  import cacm_pkg::*;
(
  input wire logic        sys_clk,
  input wire logic        srst,
  input wire logic        flag_clear,
  input wire logic [15:0] counter_value,
  input wire logic        module_io_pin_in,
  input wire logic        module_io_pin_out,
  input wire logic        module_io_pin_level,
  input wire logic [7:0]  module_mode,
  input wire logic [7:0]  capture_low_byte,
  input wire logic [7:0]  capture_high_byte,
  input wire logic        module_event_flag,
  input wire logic        event_irq
);
  wire [7:0]  m   = module_mode;                              // mode fields
  wire [15:0] cap = {capture_high_byte, capture_low_byte};    // capture value
  default clocking @(posedge sys_clk); endclocking
  default disable iff (srst);
  property p_rise; $rose(module_io_pin_level) && m[5] && $stable(counter_value) |=> module_event_flag && cap == $past(counter_value); endproperty
  a_rise: assert property (p_rise) else $error("rise capture");
  property p_fall; $fell(module_io_pin_level) && m[4] |=> module_event_flag; endproperty
  a_fall: assert property (p_fall) else $error("fall capture");
  property p_irq; event_irq == (module_event_flag && m[0]); endproperty
  a_irq: assert property (p_irq) else $error("irq");
  property p_hold; module_event_flag && !flag_clear |=> module_event_flag; endproperty
  a_hold: assert property (p_hold) else $error("flag lost");
  property p_level; $stable(module_io_pin_in) [*3] |-> module_io_pin_level == module_io_pin_in; endproperty
  a_level: assert property (p_level) else $error("level");
  property p_match; m[6] && m[3] && counter_value == cap |=> module_event_flag; endproperty
  a_match: assert property (p_match) else $error("match");
  property p_tog; m[6] && m[2] && !m[1] && counter_value == cap |=> module_io_pin_out != $past(module_io_pin_out); endproperty
  a_tog: assert property (p_tog) else $error("toggle");
  property p_pwm; m[6] && m[1] && !m[2] |=> module_io_pin_out == ($past(m[7]) ? $past(counter_value) >= $past(cap) : $past(counter_value[7:0]) >= $past(capture_low_byte)); endproperty
  a_pwm: assert property (p_pwm) else $error("pwm");
endmodule // cacm_module_asserts
bind cacm_module cacm_module_asserts u_asserts (.sys_clk, .srst, .flag_clear, .counter_value, .module_io_pin_in,
  .module_io_pin_out, .module_io_pin_level, .module_mode, .capture_low_byte, .capture_high_byte,
  .module_event_flag, .event_irq);

//--- tb/cacm_pin_source.sv
// Purpose: external source for the module pin
// Assumes: bench asks for a level, source paces it
// Notes:   a level never stands under two clocks
`timescale 1ns/1ps
module cacm_pin_source
(
  input  wire logic sys_clk,
  input  wire logic want_level,
  output logic      pin_level
);
  logic held_r = 1'b1; // old level has stood long enough
  initial pin_level = 1'b0;
  // short pulses would be lost by the synchroniser, so pace them
  always @(negedge sys_clk)
  begin
    held_r <= 1'b1;
    if (held_r && want_level != pin_level)
    begin
      pin_level <= want_level;
      held_r    <= 1'b0;
    end
  end
endmodule // cacm_pin_source

//--- tb/cacm_module_bench.sv
// Purpose: self-checking bench for the capture/compare module
// Assumes: inputs change on falling edges
// Notes:   counter held still around pin edges
`timescale 1ns/1ps
module cacm_module_bench
  import cacm_pkg::*;
;
  logic         sys_clk = 1'b0, srst = 1'b1, flag_clear = 1'b0, low_wr = 1'b0, high_wr = 1'b0, want = 1'b0;
  cacm_sfr_wr_t sfr_wr = '0;            // software write
  logic [15:0]  counter_value = 16'h0000; // shared counter
  logic         src, pout, oe_n, lvl, flag, irq;
  logic [7:0]   mode, lo, hi;
  int           fails = 0, checks_done = 0;
  wire          pin = oe_n ? src : pout; // pin wire, module drives when oe_n low
  always #2 sys_clk = ~sys_clk;
  cacm_pin_source u_src (.sys_clk(sys_clk), .want_level(want), .pin_level(src));
  cacm_module u_dut (.sys_clk(sys_clk), .srst(srst), .sfr_wr(sfr_wr), .flag_clear(flag_clear), .low_wr(low_wr),
    .high_wr(high_wr), .counter_value(counter_value), .module_io_pin_in(pin), .module_io_pin_out(pout),
    .module_io_pin_oe_n(oe_n), .module_io_pin_level(lvl), .module_mode(mode), .capture_low_byte(lo),
    .capture_high_byte(hi), .module_event_flag(flag), .event_irq(irq));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
  begin
    checks_done++;
    if (got !== exp)
    begin
      fails++;
      $display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
    end
  end
  endtask
  task automatic w(input int n);
    repeat (n) @(negedge sys_clk);
  endtask
  // one-cycle pulses; a capture edge takes three clocks to land
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
  begin
    sfr_wr <= '{wr: 1'b1, addr: a, data: d};
    w(1);
    sfr_wr.wr <= 1'b0;
    w(1);
  end
  endtask
  task automatic pulse(input logic l, input logic h, input logic c, input logic [7:0] d);
  begin
    {low_wr, high_wr, flag_clear} <= {l, h, c};
    sfr_wr.data <= d;
    w(1);
    {low_wr, high_wr, flag_clear} <= 3'h0;
    w(1);
  end
  endtask
  task automatic pin_to(input logic l);
  begin
    want <= l;
    w(6);
  end
  endtask
  task automatic end_of_test;
  begin
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  end
  endtask
  initial
  begin
    w(12);
    srst <= 1'b0;
    w(1);
    chk({oe_n, flag, irq, mode, hi, lo}, 27'h4000000); // reset values
    counter_value <= 16'h1234;
    wr(CACM_MODE0_ADDR, 8'h21);
    pin_to(1'b1);
    chk({flag, irq, hi, lo}, 24'h31234);
    w(20);
    chk(flag, 1'b1);
    pulse(1'b0, 1'b0, 1'b1, 8'h00);
    pin_to(1'b0);
    chk({flag, lvl}, 2'b00);
    $display("test rising capture done");
    wr(CACM_MODE0_ADDR, 8'h30);
    counter_value <= 16'habcd;
    pin_to(1'b1);
    chk({lvl, hi, lo}, 17'h1abcd);
    pulse(1'b0, 1'b0, 1'b1, 8'h00);
    counter_value <= 16'h5678;
    pin_to(1'b0);
    chk({flag, irq, lvl, hi, lo}, 19'h45678);
    wr(CACM_MODE1_ADDR, 8'hff);
    chk(mode, 8'h30);
    $display("test both edges done");
    pulse(1'b0, 1'b0, 1'b1, 8'h00);
    pulse(1'b1, 1'b0, 1'b0, 8'h42);
    pulse(1'b0, 1'b1, 1'b0, 8'h00);
    wr(CACM_MODE0_ADDR, 8'h48);
    counter_value <= 16'h0042;
    w(2);
    chk(flag, 1'b1);
    counter_value <= 16'h0120;
    wr(CACM_MODE0_ADDR, 8'hc2);
    chk({oe_n, pout}, 2'b01);
    wr(CACM_MODE0_ADDR, 8'h42);
    chk({oe_n, pout}, 2'b00);
    wr(CACM_MODE0_ADDR, 8'h44);
    counter_value <= 16'h0042;
    w(1);
    counter_value <= 16'h0043;
    w(1);
    chk({oe_n, pout}, 2'b01);
    wr(CACM_MODE0_ADDR, 8'h46);
    counter_value <= 16'h0042;
    w(1);
    counter_value <= 16'h0043;
    w(1);
    chk({oe_n, pout}, 2'b00);
    pulse(1'b0, 1'b0, 1'b1, 8'h00);
    wr(CACM_MODE0_ADDR, 8'h4a);
    chk(flag, 1'b0);
    counter_value <= 16'h0342;
    w(2);
    chk(flag, 1'b1);
    $display("test compare modes done");
    end_of_test();
  end
  // the tests need under 400 clocks; allow ten times that
  initial
  begin
    #16000;
    fails++;
    end_of_test();
  end
endmodule // cacm_module_bench
